// ==== map_clk_decoder.sv ====
// What this block does
// R1 - The decoder takes a 16-bit CPU address, covering a 64 KB space.
// R2 - FLASH of 32256 bytes, EEPROM of 512 bytes and RAM of 1024 bytes each get their own select.
// R3 - 48 bytes of vectors and 307 bytes of monitor ROM each get their own select.
// R4 - An access to an unimplemented address raises an illegal-address reset only while that reset is enabled.
// R5 - The CPU must not access reserved locations, whose effect is undefined.
// R6 - Zero-page peripheral registers sit at 0000 to 004F.
// R7 - Break status sits at FE00, reset status at FE01 and break flag control at FE03.
// R8 - Breakpoint high at FE0C, low at FE0D, status/control at FE0E and low-voltage status at FE0F.
// R9 - EEPROM registers sit at FE10, FE11, FE1A, FE1B, FE1C, FE1D and FE1F.
// R10 - FLASH control at FE08, FLASH block protect at FF7E and watchdog control at FFFF.
// R11 - The bus clock is the clock generator output divided by two and clocks CPU, RAM, ROM, PIT and KBI.
// R12 - The buffered oscillator clock copies the crystal input; the generator output comes from PLL or oscillator.
// R13 - Converter and EEPROM clocks each select buffered oscillator or bus clock.
// R14 - Each timer clock selects bus clock or its own external pin.
// R15 - At most one select is active per address and anything outside all regions is unimplemented.
`timescale 1ns/1ps
module map_clk_decoder
  import map_clk_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] cpu_addr,
  input  wire logic              cpu_access,
  input  wire logic              illegal_reset_enable,
  input  wire logic              crystal_input,
  input  wire logic              pll_tick,
  input  wire logic              use_pll,
  input  wire logic              adc_use_osc,
  input  wire logic              eeprom_use_osc,
  input  wire logic              timer_a_ext_clock,
  input  wire logic              timer_b_ext_clock,
  input  wire logic              timer_a_use_ext,
  input  wire logic              timer_b_use_ext,
  output sel_t                   sel_q,
  output logic                   unimplemented_q,
  output logic                   illegal_reset_q,
  output clk_en_t                clk_en_q
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  sel_t sel_d;
  logic unimpl_hit;
  logic unimplemented_d;
  logic illegal_reset_d;

  // Priority chain keeps the result one-hot even where ranges touch
  always_comb begin
    sel_d = SEL_NONE;
    unimpl_hit = 1'b0;
    unique case (cpu_addr) // see R1
      SYS_BREAK_STATUS_A:    sel_d[SEL_SYS_BRK_ST] = 1'b1; // see R7
      SYS_RESET_STATUS_A:    sel_d[SEL_SYS_RST_ST] = 1'b1; // see R7
      SYS_BREAK_FLAG_CTRL_A: sel_d[SEL_SYS_BRK_FC] = 1'b1; // see R7
      FLASH_CONTROL_A:       sel_d[SEL_FLASH_CTRL] = 1'b1; // see R10
      BRK_ADDR_HIGH_A:       sel_d[SEL_BRK_HIGH]   = 1'b1; // see R8
      BRK_ADDR_LOW_A:        sel_d[SEL_BRK_LOW]    = 1'b1; // see R8
      BRK_STATUS_CTRL_A:     sel_d[SEL_BRK_SC]     = 1'b1; // see R8
      LOW_VOLTAGE_STATUS_A:  sel_d[SEL_LOW_VOLT]   = 1'b1; // see R8
      EE_NV_DIV_HIGH_A:      sel_d[SEL_EE_NVDIV_H] = 1'b1; // see R9
      EE_NV_DIV_LOW_A:       sel_d[SEL_EE_NVDIV_L] = 1'b1; // see R9
      EE_TB_DIV_HIGH_A:      sel_d[SEL_EE_TBDIV_H] = 1'b1; // see R9
      EE_TB_DIV_LOW_A:       sel_d[SEL_EE_TBDIV_L] = 1'b1; // see R9
      EE_NV_CFG_A:           sel_d[SEL_EE_NV_CFG]  = 1'b1; // see R9
      EE_CONTROL_A:          sel_d[SEL_EE_CTRL]    = 1'b1; // see R9
      EE_ARRAY_CFG_A:        sel_d[SEL_EE_ARR_CFG] = 1'b1; // see R9
      FLASH_BLOCK_PROT_A:    sel_d[SEL_FLASH_BP]   = 1'b1; // see R10
      // Watchdog wins over the last vector byte
      WATCHDOG_CONTROL_A:    sel_d[SEL_WATCHDOG]   = 1'b1; // see R10 see R15
      RSV_FE02_A,
      RSV_FE1E_A:            sel_d[SEL_RESERVED]   = 1'b1; // see R5
      default: begin
        if (cpu_addr <= ZERO_PAGE_HI) begin
          sel_d[SEL_ZERO_PAGE] = 1'b1; // see R6
        end else if (cpu_addr >= RAM_LO && cpu_addr <= RAM_HI) begin
          sel_d[SEL_RAM] = 1'b1; // see R2
        end else if (cpu_addr >= EEPROM_LO && cpu_addr <= EEPROM_HI) begin
          sel_d[SEL_EEPROM] = 1'b1; // see R2
        end else if (cpu_addr >= FLASH_LO && cpu_addr <= FLASH_HI) begin
          sel_d[SEL_FLASH] = 1'b1; // see R2
        end else if (cpu_addr >= MONITOR_LO && cpu_addr <= MONITOR_HI) begin
          sel_d[SEL_MONITOR] = 1'b1; // see R3
        end else if (cpu_addr >= VECTOR_LO && cpu_addr <= VECTOR_HI) begin
          sel_d[SEL_VECTORS] = 1'b1; // see R3
        end else if ((cpu_addr >= RSV_FE04_LO && cpu_addr <= RSV_FE07_HI)
                  || (cpu_addr >= RSV_FE09_LO && cpu_addr <= RSV_FE0B_HI)
                  || (cpu_addr >= RSV_FE12_LO && cpu_addr <= RSV_FE19_HI)
                  || (cpu_addr >= RSV_FLASH_LO && cpu_addr <= RSV_FLASH_HI)) begin
          // Reserved holes never raise a reset; behaviour is left to the CPU
          sel_d[SEL_RESERVED] = 1'b1; // see R5
        end else begin
          unimpl_hit = 1'b1; // see R15
        end
      end
    endcase
    if (!cpu_access) begin
      sel_d = SEL_NONE;
      unimpl_hit = 1'b0;
    end
    unimplemented_d = unimpl_hit;
    illegal_reset_d = unimpl_hit & illegal_reset_enable; // see R4
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q           <= SEL_NONE;
      unimplemented_q <= 1'b0;
      illegal_reset_q <= 1'b0;
    end else begin
      sel_q           <= sel_d;
      unimplemented_q <= unimplemented_d;
      illegal_reset_q <= illegal_reset_d;
    end
  end

  // ****************************************************************
  // Clock derivation
  // ****************************************************************
  logic    osc_tick;
  logic    tim_a_pin_tick;
  logic    tim_b_pin_tick;
  logic    cgm_tick;
  logic    bus_tick;
  logic    div_phase_q;
  logic    div_phase_d;
  clk_en_t clk_en_d;

  // Crystal must run below half of ref_clk to be seen
  pin_edge_sync u_osc_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (crystal_input),
    .rise    (osc_tick)
  );

  pin_edge_sync u_tim_a_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (timer_a_ext_clock),
    .rise    (tim_a_pin_tick)
  );

  pin_edge_sync u_tim_b_sync (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .pin     (timer_b_ext_clock),
    .rise    (tim_b_pin_tick)
  );

  always_comb begin
    cgm_tick    = use_pll ? pll_tick : osc_tick; // see R12
    bus_tick    = cgm_tick & div_phase_q; // see R11
    div_phase_d = cgm_tick ? ~div_phase_q : div_phase_q; // see R11
    clk_en_d.clock_gen_output   = cgm_tick; // see R12
    clk_en_d.osc_buffered_clock = osc_tick; // see R12
    clk_en_d.bus                = bus_tick; // see R11
    clk_en_d.adc                = adc_use_osc ? osc_tick : bus_tick; // see R13
    clk_en_d.eeprom             = eeprom_use_osc ? osc_tick : bus_tick; // see R13
    clk_en_d.timer_a            = timer_a_use_ext ? tim_a_pin_tick : bus_tick; // see R14
    clk_en_d.timer_b            = timer_b_use_ext ? tim_b_pin_tick : bus_tick; // see R14
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_phase_q <= 1'b0;
      clk_en_q    <= CLK_EN_NONE;
    end else begin
      div_phase_q <= div_phase_d;
      clk_en_q    <= clk_en_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_SEL_ONEHOT: assert property (@(posedge ref_clk) disable iff (!resetn) // see R15
    $onehot0({sel_q, unimplemented_q}))
    else $error("more than one select active");

  AST_FLASH_RAM_SEL: assert property (@(posedge ref_clk) disable iff (!resetn) // see R2
    cpu_access && cpu_addr >= FLASH_LO && cpu_addr <= FLASH_HI |=> sel_q[SEL_FLASH] && !sel_q[SEL_RAM])
    else $error("flash address not selected");

  AST_MONITOR_SEL: assert property (@(posedge ref_clk) disable iff (!resetn) // see R3
    cpu_access && cpu_addr >= MONITOR_LO && cpu_addr <= MONITOR_HI |=> sel_q[SEL_MONITOR])
    else $error("monitor address not selected");

  AST_ILLEGAL_RAISED: assert property (@(posedge ref_clk) disable iff (!resetn) // see R4
    unimplemented_q && $past(illegal_reset_enable) |-> illegal_reset_q)
    else $error("illegal address reset missing");

  AST_ILLEGAL_GATED: assert property (@(posedge ref_clk) disable iff (!resetn) // see R4
    !illegal_reset_enable |=> !illegal_reset_q)
    else $error("illegal reset raised while disabled");

  AST_ZERO_PAGE: assert property (@(posedge ref_clk) disable iff (!resetn) // see R6
    cpu_access && cpu_addr <= ZERO_PAGE_HI |=> sel_q[SEL_ZERO_PAGE] ##1 !sel_q[SEL_ZERO_PAGE] || $past(cpu_access))
    else $error("zero page not selected");

  AST_RESET_STATUS: assert property (@(posedge ref_clk) disable iff (!resetn) // see R7
    cpu_access && cpu_addr == SYS_RESET_STATUS_A |=> sel_q[SEL_SYS_RST_ST] && !unimplemented_q)
    else $error("reset status register not selected");

  AST_BRK_LOW: assert property (@(posedge ref_clk) disable iff (!resetn) // see R8
    cpu_access && cpu_addr == BRK_ADDR_LOW_A |=> sel_q[SEL_BRK_LOW])
    else $error("breakpoint low not selected");

  AST_EE_ARRAY: assert property (@(posedge ref_clk) disable iff (!resetn) // see R9
    cpu_access && cpu_addr == EE_ARRAY_CFG_A |=> sel_q[SEL_EE_ARR_CFG])
    else $error("eeprom array config not selected");

  AST_WATCHDOG: assert property (@(posedge ref_clk) disable iff (!resetn) // see R10
    cpu_access && cpu_addr == WATCHDOG_CONTROL_A |=> sel_q[SEL_WATCHDOG] && !sel_q[SEL_VECTORS])
    else $error("watchdog control not selected");

  AST_BUS_HALF: assert property (@(posedge ref_clk) disable iff (!resetn) // see R11
    clk_en_q.bus |-> clk_en_q.clock_gen_output && $past(div_phase_q) && !div_phase_q)
    else $error("bus clock not half of generator clock");

  AST_OSC_COPY: assert property (@(posedge ref_clk) disable iff (!resetn) // see R12
    osc_tick && !use_pll |=> clk_en_q.osc_buffered_clock && clk_en_q.clock_gen_output)
    else $error("oscillator tick not forwarded");

  AST_ADC_OSC: assert property (@(posedge ref_clk) disable iff (!resetn) // see R13
    adc_use_osc && !osc_tick |=> !clk_en_q.adc)
    else $error("converter clock not from oscillator");

  AST_TIMER_A_BUS: assert property (@(posedge ref_clk) disable iff (!resetn) // see R14
    !timer_a_use_ext && bus_tick |=> clk_en_q.timer_a && clk_en_q.bus)
    else $error("timer a clock not from bus clock");

endmodule // map_clk_decoder

// ==== map_clk_pkg.sv ====
package map_clk_pkg;

  // ****************************************************************
  // Address space
  // ****************************************************************
  localparam int unsigned ADDR_W = 16;

  localparam logic [15:0] ZERO_PAGE_LO = 16'h0000;
  localparam logic [15:0] ZERO_PAGE_HI = 16'h004f;
  // Array bases are placement choices; sizes are fixed
  localparam logic [15:0] RAM_LO       = 16'h0050;
  localparam logic [15:0] RAM_SIZE     = 16'h0400;
  localparam logic [15:0] RAM_HI       = RAM_LO + RAM_SIZE - 16'h0001;
  localparam logic [15:0] EEPROM_LO    = 16'h0800;
  localparam logic [15:0] EEPROM_SIZE  = 16'h0200;
  localparam logic [15:0] EEPROM_HI    = EEPROM_LO + EEPROM_SIZE - 16'h0001;
  localparam logic [15:0] FLASH_LO     = 16'h8000;
  localparam logic [15:0] FLASH_SIZE   = 16'h7e00;
  localparam logic [15:0] FLASH_HI     = FLASH_LO + FLASH_SIZE - 16'h0001;
  localparam logic [15:0] MONITOR_LO   = 16'hfe20;
  localparam logic [15:0] MONITOR_SIZE = 16'h0133;
  localparam logic [15:0] MONITOR_HI   = MONITOR_LO + MONITOR_SIZE - 16'h0001;
  localparam logic [15:0] VECTOR_LO    = 16'hffd0;
  localparam logic [15:0] VECTOR_SIZE  = 16'h0030;
  localparam logic [15:0] VECTOR_HI    = VECTOR_LO + VECTOR_SIZE - 16'h0001;
  localparam logic [15:0] RSV_FLASH_LO = 16'hffc0;
  localparam logic [15:0] RSV_FLASH_HI = 16'hffcf;

  // ****************************************************************
  // Single register addresses
  // ****************************************************************
  localparam logic [15:0] SYS_BREAK_STATUS_A    = 16'hfe00;
  localparam logic [15:0] SYS_RESET_STATUS_A    = 16'hfe01;
  localparam logic [15:0] SYS_BREAK_FLAG_CTRL_A = 16'hfe03;
  localparam logic [15:0] FLASH_CONTROL_A       = 16'hfe08;
  localparam logic [15:0] BRK_ADDR_HIGH_A       = 16'hfe0c;
  localparam logic [15:0] BRK_ADDR_LOW_A        = 16'hfe0d;
  localparam logic [15:0] BRK_STATUS_CTRL_A     = 16'hfe0e;
  localparam logic [15:0] LOW_VOLTAGE_STATUS_A  = 16'hfe0f;
  localparam logic [15:0] EE_NV_DIV_HIGH_A      = 16'hfe10;
  localparam logic [15:0] EE_NV_DIV_LOW_A       = 16'hfe11;
  localparam logic [15:0] EE_TB_DIV_HIGH_A      = 16'hfe1a;
  localparam logic [15:0] EE_TB_DIV_LOW_A       = 16'hfe1b;
  localparam logic [15:0] EE_NV_CFG_A           = 16'hfe1c;
  localparam logic [15:0] EE_CONTROL_A          = 16'hfe1d;
  localparam logic [15:0] EE_ARRAY_CFG_A        = 16'hfe1f;
  localparam logic [15:0] FLASH_BLOCK_PROT_A    = 16'hff7e;
  localparam logic [15:0] WATCHDOG_CONTROL_A    = 16'hffff;
  // Reserved holes inside the high register page
  localparam logic [15:0] RSV_FE02_A            = 16'hfe02;
  localparam logic [15:0] RSV_FE04_LO           = 16'hfe04;
  localparam logic [15:0] RSV_FE07_HI           = 16'hfe07;
  localparam logic [15:0] RSV_FE09_LO           = 16'hfe09;
  localparam logic [15:0] RSV_FE0B_HI           = 16'hfe0b;
  localparam logic [15:0] RSV_FE12_LO           = 16'hfe12;
  localparam logic [15:0] RSV_FE19_HI           = 16'hfe19;
  localparam logic [15:0] RSV_FE1E_A            = 16'hfe1e;

  // ****************************************************************
  // Select vector bit positions
  // ****************************************************************
  localparam int unsigned SEL_ZERO_PAGE   = 0;
  localparam int unsigned SEL_RAM         = 1;
  localparam int unsigned SEL_EEPROM      = 2;
  localparam int unsigned SEL_FLASH       = 3;
  localparam int unsigned SEL_MONITOR     = 4;
  localparam int unsigned SEL_VECTORS     = 5;
  localparam int unsigned SEL_SYS_BRK_ST  = 6;
  localparam int unsigned SEL_SYS_RST_ST  = 7;
  localparam int unsigned SEL_SYS_BRK_FC  = 8;
  localparam int unsigned SEL_FLASH_CTRL  = 9;
  localparam int unsigned SEL_BRK_HIGH    = 10;
  localparam int unsigned SEL_BRK_LOW     = 11;
  localparam int unsigned SEL_BRK_SC      = 12;
  localparam int unsigned SEL_LOW_VOLT    = 13;
  localparam int unsigned SEL_EE_NVDIV_H  = 14;
  localparam int unsigned SEL_EE_NVDIV_L  = 15;
  localparam int unsigned SEL_EE_TBDIV_H  = 16;
  localparam int unsigned SEL_EE_TBDIV_L  = 17;
  localparam int unsigned SEL_EE_NV_CFG   = 18;
  localparam int unsigned SEL_EE_CTRL     = 19;
  localparam int unsigned SEL_EE_ARR_CFG  = 20;
  localparam int unsigned SEL_FLASH_BP    = 21;
  localparam int unsigned SEL_WATCHDOG    = 22;
  localparam int unsigned SEL_RESERVED    = 23;
  localparam int unsigned SEL_W           = 24;

  typedef logic [SEL_W-1:0] sel_t;
  localparam sel_t SEL_NONE = '0;

  // ****************************************************************
  // Clock enables
  // ****************************************************************
  typedef struct packed {
    logic clock_gen_output;
    logic osc_buffered_clock;
    logic bus;
    logic adc;
    logic eeprom;
    logic timer_a;
    logic timer_b;
  } clk_en_t;

  localparam clk_en_t CLK_EN_NONE = '0;
  localparam int unsigned SYNC_STAGES = 2;

endpackage

// ==== pin_edge_sync.sv ====
`timescale 1ns/1ps
module pin_edge_sync
  import map_clk_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin,
  output logic      rise
);

  // ****************************************************************
  // Two-stage synchroniser, third stage for edge detect
  // ****************************************************************
  logic [SYNC_STAGES:0] sync_q;
  logic [SYNC_STAGES:0] sync_d;

  always_comb begin
    sync_d = {sync_q[SYNC_STAGES-1:0], pin};
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= '0;
    end else begin
      sync_q <= sync_d;
    end
  end

  // Only stages past the first are looked at
  assign rise = sync_q[SYNC_STAGES-1] & ~sync_q[SYNC_STAGES];

endmodule // pin_edge_sync

// ==== cpu_model.sv ====
`timescale 1ns/1ps
module cpu_model
  import map_clk_pkg::*;
(
  output logic              cpu_access,
  output logic [ADDR_W-1:0] cpu_addr
);
  initial begin
    cpu_access = 1'b0;
    cpu_addr   = 16'h0000;
  end

  // ****************************************************************
  // One access per call, made just after a rising edge
  // ****************************************************************
  // Reserved places are asked for by the bench on purpose and can also come up in its random traffic
  task automatic issue(input logic v, input logic [ADDR_W-1:0] a);
    cpu_access <= v;
    // Idle bus shows a changing value, not the last address
    cpu_addr   <= v ? a : ~cpu_addr;
  endtask
endmodule // cpu_model

// ==== map_clk_decoder_tb.sv ====
`timescale 1ns/1ps
module map_clk_decoder_tb
  import map_clk_pkg::*;
;
  typedef struct {
    sel_t    sel;
    logic    unimpl;
    logic    illeg;
    clk_en_t ce;
    int      due;
  } res_t;

  localparam logic [15:0] REG_A [17] = '{SYS_BREAK_STATUS_A, SYS_RESET_STATUS_A, SYS_BREAK_FLAG_CTRL_A,
    FLASH_CONTROL_A, BRK_ADDR_HIGH_A, BRK_ADDR_LOW_A, BRK_STATUS_CTRL_A, LOW_VOLTAGE_STATUS_A, EE_NV_DIV_HIGH_A,
    EE_NV_DIV_LOW_A, EE_TB_DIV_HIGH_A, EE_TB_DIV_LOW_A, EE_NV_CFG_A, EE_CONTROL_A, EE_ARRAY_CFG_A,
    FLASH_BLOCK_PROT_A, WATCHDOG_CONTROL_A};
  localparam logic [15:0] EDGE_A [12] = '{16'h0000, 16'h004f, 16'h0050, 16'h044f, 16'h0450, 16'h07ff,
    16'h0800, 16'h09ff, 16'h0a00, 16'h7fff, 16'h8000, 16'hfdff};

  logic ref_clk, resetn, cpu_access, illegal_reset_enable, crystal_input, pll_tick, use_pll;
  logic adc_use_osc, eeprom_use_osc, timer_a_ext_clock, timer_b_ext_clock, timer_a_use_ext, timer_b_use_ext;
  logic [ADDR_W-1:0] cpu_addr;
  sel_t              sel_q;
  logic              unimplemented_q, illegal_reset_q, counting;
  clk_en_t           clk_en_q;
  res_t              exp_q[$];
  res_t              mon_e;
  int                mismatches, n_checks, nc, cyc, gcnt, xr, ar;
  int                c_gen, c_osc, c_bus, c_adc, c_ee, c_ta, c_tb;
  logic [15:0]       rnd;

  cpu_model cpu (.cpu_access(cpu_access), .cpu_addr(cpu_addr));

  map_clk_decoder uut (.ref_clk(ref_clk), .resetn(resetn), .cpu_addr(cpu_addr), .cpu_access(cpu_access),
    .illegal_reset_enable(illegal_reset_enable), .crystal_input(crystal_input), .pll_tick(pll_tick),
    .use_pll(use_pll), .adc_use_osc(adc_use_osc), .eeprom_use_osc(eeprom_use_osc),
    .timer_a_ext_clock(timer_a_ext_clock), .timer_b_ext_clock(timer_b_ext_clock),
    .timer_a_use_ext(timer_a_use_ext), .timer_b_use_ext(timer_b_use_ext), .sel_q(sel_q),
    .unimplemented_q(unimplemented_q), .illegal_reset_q(illegal_reset_q), .clk_en_q(clk_en_q));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Reference decode, worked out from the map alone
  // ****************************************************************
  function automatic res_t decode(input logic [15:0] a);
    res_t r;
    r = '{sel: SEL_NONE, unimpl: 1'b0, illeg: 1'b0, ce: CLK_EN_NONE, due: 0};
    for (int i = 0; i < 17; i++) if (a == REG_A[i]) r.sel[SEL_SYS_BRK_ST + i] = 1'b1;
    if (r.sel != SEL_NONE) return r;
    if (a <= ZERO_PAGE_HI) r.sel[SEL_ZERO_PAGE] = 1'b1;
    else if (a >= RAM_LO && a <= RAM_HI) r.sel[SEL_RAM] = 1'b1;
    else if (a >= EEPROM_LO && a <= EEPROM_HI) r.sel[SEL_EEPROM] = 1'b1;
    else if (a >= FLASH_LO && a <= FLASH_HI) r.sel[SEL_FLASH] = 1'b1;
    else if (a >= MONITOR_LO && a <= MONITOR_HI) r.sel[SEL_MONITOR] = 1'b1;
    else if (a >= VECTOR_LO && a <= VECTOR_HI) r.sel[SEL_VECTORS] = 1'b1;
    else if (a == 16'hfe02 || (a >= 16'hfe04 && a <= 16'hfe07) || (a >= 16'hfe09 && a <= 16'hfe0b) ||
             (a >= 16'hfe12 && a <= 16'hfe19) || a == 16'hfe1e || (a >= RSV_FLASH_LO && a <= RSV_FLASH_HI))
      r.sel[SEL_RESERVED] = 1'b1;
    else r.unimpl = 1'b1;
    return r;
  endfunction

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic cmp_res(input res_t e);
    n_checks++;
    if (sel_q !== e.sel || unimplemented_q !== e.unimpl || illegal_reset_q !== e.illeg || clk_en_q !== e.ce) begin
      mismatches++;
      $display("CHECK FAILED outputs expected %h %b %b %b got %h %b %b %b", e.sel, e.unimpl, e.illeg, e.ce,
               sel_q, unimplemented_q, illegal_reset_q, clk_en_q);
    end
  endtask

  task automatic cmp_cnt(input string name, input int exp_v, input int got);
    n_checks++;
    if (exp_v != got) begin
      mismatches++;
      $display("CHECK FAILED %s expected %0d got %0d", name, exp_v, got);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Driver: one cycle of traffic plus its expected result
  // ****************************************************************
  task automatic step(input logic v, input logic [15:0] a, input logic en);
    res_t e;
    logic [15:0] r;
    logic gen;
    rnd = lfsr_next(rnd);
    r = rnd;
    @(posedge ref_clk);
    cpu.issue(v, a);
    illegal_reset_enable <= en;
    pll_tick <= r[0];
    use_pll <= r[1];
    adc_use_osc <= r[2];
    eeprom_use_osc <= r[3];
    timer_a_use_ext <= r[4];
    timer_b_use_ext <= r[5];
    e = decode(a);
    if (!v) begin
      e.sel = SEL_NONE;
      e.unimpl = 1'b0;
    end
    e.illeg = e.unimpl & en;
    // Crystal and timer pins are quiet here, so only the PLL path ticks
    gen = r[0] & r[1];
    if (gen) gcnt++;
    e.ce.clock_gen_output = gen;
    e.ce.bus = gen & (gcnt % 2 == 0);
    e.ce.adc = e.ce.bus & ~r[2];
    e.ce.eeprom = e.ce.bus & ~r[3];
    e.ce.timer_a = e.ce.bus & ~r[4];
    e.ce.timer_b = e.ce.bus & ~r[5];
    e.due = nc + 2;
    exp_q.push_back(e);
  endtask

  task automatic do_reset();
    @(posedge ref_clk);
    cpu.issue(1'b0, 16'h0000);
    pll_tick <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1 cmp_res('{sel: SEL_NONE, unimpl: 1'b0, illeg: 1'b0, ce: CLK_EN_NONE, due: 0});
    @(posedge ref_clk);
    resetn <= 1'b1;
    gcnt = 0;
  endtask

  // ****************************************************************
  // Monitor and counters
  // ****************************************************************
  always @(negedge ref_clk) begin
    nc = nc + 1;
    while (exp_q.size() > 0 && exp_q[0].due <= nc) begin
      mon_e = exp_q.pop_front();
      if (mon_e.due == nc) cmp_res(mon_e);
    end
    if (counting) begin
      c_gen += clk_en_q.clock_gen_output;
      c_osc += clk_en_q.osc_buffered_clock;
      c_bus += clk_en_q.bus;
      c_adc += clk_en_q.adc;
      c_ee  += clk_en_q.eeprom;
      c_ta  += clk_en_q.timer_a;
      c_tb  += clk_en_q.timer_b;
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    {resetn, illegal_reset_enable, crystal_input, pll_tick, use_pll, adc_use_osc, eeprom_use_osc} = '0;
    {timer_a_ext_clock, timer_b_ext_clock, timer_a_use_ext, timer_b_use_ext, counting} = '0;
    {mismatches, n_checks, nc, cyc, gcnt, xr, ar, c_gen, c_osc, c_bus, c_adc, c_ee, c_ta, c_tb} = '0;
    rnd = 16'h3aa1;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int k = 0; k < 24; k++) step(1'b1, EDGE_A[k % 12], k >= 12);
    for (int k = 0; k < 512; k++) step(1'b1, 16'hfe00 + k[15:0], k[0]);
    for (int k = 0; k < 1500; k++) step(rnd[7] | rnd[8], lfsr_next(rnd), rnd[9]);
    // Mid-run reset, then the pin-driven clock sources
    do_reset();
    @(posedge ref_clk);
    use_pll <= 1'b0;
    adc_use_osc <= 1'b1;
    eeprom_use_osc <= 1'b0;
    timer_a_use_ext <= 1'b1;
    timer_b_use_ext <= 1'b0;
    counting = 1'b1;
    for (int i = 0; i < 240; i++) begin
      @(posedge ref_clk);
      crystal_input <= 1'((i / 3) % 2);
      timer_a_ext_clock <= 1'((i / 4) % 2);
      timer_b_ext_clock <= 1'((i / 5) % 2);
      if (i % 6 == 3) xr++;
      if (i % 8 == 4) ar++;
    end
    @(posedge ref_clk);
    {crystal_input, timer_a_ext_clock, timer_b_ext_clock} <= 3'b000;
    repeat (10) @(posedge ref_clk);
    cmp_cnt("generator ticks", xr, c_gen);
    cmp_cnt("oscillator ticks", xr, c_osc);
    cmp_cnt("bus ticks", xr / 2, c_bus);
    cmp_cnt("converter ticks", xr, c_adc);
    cmp_cnt("eeprom ticks", xr / 2, c_ee);
    cmp_cnt("timer a ticks", ar, c_ta);
    cmp_cnt("timer b ticks", xr / 2, c_tb);
    final_report();
  end
endmodule // map_clk_decoder_tb
